// ### verilog/csd_pkg.sv
package csd_pkg;

    localparam int CSD_W = 128;
    localparam int RCA_W = 16;

    // field positions
    localparam int FFG_BIT = 15;
    localparam int COPY_BIT = 14;
    localparam int PWP_BIT = 13;
    localparam int TWP_BIT = 12;
    localparam int CRC_LSB = 1;
    localparam int CRC_W = 7;

    // fixed image, writable fields at their reset values
    localparam logic [127:0] CSD_RESET = {
        2'h1, 6'h00, 8'h0E, 8'h00, 8'h32, 12'h5B5, 4'h9,
        1'h0, 1'h0, 1'h0, 1'h0, 6'h00, 22'h0001CDF, 1'h0,
        1'h1, 7'h3F, 7'h00, 1'h0, 2'h0, 3'h2, 4'h9, 1'h0,
        5'h00, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 2'h0, 7'h6B, 1'h1};

    // bits software may ever change
    localparam logic [127:0] CSD_WR_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_F0FE;
    localparam logic [127:0] CSD_OTP_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_E000;

    localparam logic [15:0] RCA_RESET = 16'h0000;

endpackage

// ### verilog/csd_check.sv
`timescale 1ns/10ps
// checks a program image against the current register
module csd_check (
    input wire logic [127:0] cur,
    input wire logic [127:0] req,
    input wire logic [2:0] otp_done,
    output logic ok
);
    wire [127:0] diff = cur ^ req;
    wire ro_touched = |(diff & ~csd_pkg::CSD_WR_MASK);
    wire otp_rewrite = |(diff[15:13] & otp_done);
    assign ok = !ro_touched && !otp_rewrite;
endmodule // csd_check

// ### verilog/csd_regs.sv
`timescale 1ns/10ps
// How it works
// - 128-bit card data register, read back whole on request.
// - writable fields change only through the program card data command.
// - code_a group, copy, permanent protect: one-time writable, reset zero.
// - temporary write protect bit freely rewritable, reset zero.
// - all other fields read-only and fixed, except the checksum in bits 7:1, which is writable.
// - bit 0 always reads one.
// - structure version reads 01b, next six bits zero.
// - access time 0Eh, clock-cycle access zero, transfer rate 32h.
// - command classes field reads 5B5h.
// - device size fixed capacity code, bit 47 zero.
// - single-block erase enable one, sector size field fixed.
// - protect group size and enable read zero.
// - speed factor 010b, write block length 1001b, no partial writes.
// - writable 16-bit relative card address register.
// - no driver-stage register exists.
module csd_regs (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic csd_read,
    input wire logic program_card_data_command,
    input wire logic [127:0] program_data,
    input wire logic rca_write,
    input wire logic [15:0] rca_wdata,
    output logic [127:0] csd_rdata,
    output logic csd_rvalid,
    output logic program_done,
    output logic program_error,
    output logic [15:0] relative_card_address
);

    ////////////////////////////////////////////////////////////////
    logic [127:0] card_specific_data_r;
    logic [2:0] otp_done_r;
    logic [2:0] otp_done_nxt;
    logic prog_ok;
    wire [127:0] csd_nxt;

    csd_check u_check (
        .cur(card_specific_data_r),
        .req(program_data),
        .otp_done(otp_done_r),
        .ok(prog_ok)
    );

    // only writable bits follow the request; the rest stay fixed
    assign csd_nxt = (csd_pkg::CSD_RESET & ~csd_pkg::CSD_WR_MASK)
        | (program_data & csd_pkg::CSD_WR_MASK);
    // a one-time bit locks once it has been set
    assign otp_done_nxt = otp_done_r | program_data[15:13];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            card_specific_data_r <= csd_pkg::CSD_RESET;
            otp_done_r <= 3'h0;
        end else if (program_card_data_command && prog_ok) begin
            card_specific_data_r <= csd_nxt;
            otp_done_r <= otp_done_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            program_done <= 1'b0;
            program_error <= 1'b0;
        end else begin
            program_done <= program_card_data_command && prog_ok;
            program_error <= program_card_data_command && !prog_ok;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            csd_rdata <= 128'h0;
            csd_rvalid <= 1'b0;
        end else begin
            csd_rvalid <= csd_read;
            if (csd_read) begin
                csd_rdata <= card_specific_data_r;
            end
        end
    end

    // no driver-stage register is kept
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            relative_card_address <= csd_pkg::RCA_RESET;
        end else if (rca_write) begin
            relative_card_address <= rca_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // named views of the stored image
    wire [1:0] structure_version;
    wire [5:0] rsvd_top;
    wire [7:0] access_time;
    wire [7:0] clock_cycle_access;
    wire [7:0] transfer_rate;
    wire [11:0] command_classes;
    wire [3:0] read_block_length;
    wire partial_read_allowed;
    wire write_misaligned_allowed;
    wire read_misaligned_allowed;
    wire driver_stage_present;
    wire [5:0] rsvd_mid;
    wire [21:0] device_size;
    wire rsvd_47;
    wire single_block_erase_enable;
    wire [6:0] erase_sector_size;
    wire [6:0] protect_group_size;
    wire protect_group_enable;
    wire [1:0] rsvd_30;
    wire [2:0] read_to_write_factor;
    wire [3:0] write_block_length;
    wire partial_write_allowed;
    wire [4:0] rsvd_low;
    wire [1:0] code_a;
    wire [1:0] rsvd_9;
    wire [6:0] checksum;
    wire unused_one;

    assign structure_version = card_specific_data_r[127:126];
    assign rsvd_top = card_specific_data_r[125:120];
    assign access_time = card_specific_data_r[119:112];
    assign clock_cycle_access = card_specific_data_r[111:104];
    assign transfer_rate = card_specific_data_r[103:96];
    assign command_classes = card_specific_data_r[95:84];
    assign read_block_length = card_specific_data_r[83:80];
    assign partial_read_allowed = card_specific_data_r[79];
    assign write_misaligned_allowed = card_specific_data_r[78];
    assign read_misaligned_allowed = card_specific_data_r[77];
    assign driver_stage_present = card_specific_data_r[76];
    assign rsvd_mid = card_specific_data_r[75:70];
    assign device_size = card_specific_data_r[69:48];
    assign rsvd_47 = card_specific_data_r[47];
    assign single_block_erase_enable = card_specific_data_r[46];
    assign erase_sector_size = card_specific_data_r[45:39];
    assign protect_group_size = card_specific_data_r[38:32];
    assign protect_group_enable = card_specific_data_r[31];
    assign rsvd_30 = card_specific_data_r[30:29];
    assign read_to_write_factor = card_specific_data_r[28:26];
    assign write_block_length = card_specific_data_r[25:22];
    assign partial_write_allowed = card_specific_data_r[21];
    assign rsvd_low = card_specific_data_r[20:16];
    assign code_a = card_specific_data_r[11:10];
    assign rsvd_9 = card_specific_data_r[9:8];
    assign checksum = card_specific_data_r[7:1];
    assign unused_one = card_specific_data_r[0];

    ////////////////////////////////////////////////////////////////
    // every fixed field keeps its image value
    sv_field_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        structure_version == csd_pkg::CSD_RESET[127:126])
        else $error("structure version changed");
    top_rsvd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rsvd_top == csd_pkg::CSD_RESET[125:120])
        else $error("top reserved bits changed");
    acc_time_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        access_time == csd_pkg::CSD_RESET[119:112])
        else $error("access time changed");
    clk_access_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clock_cycle_access == csd_pkg::CSD_RESET[111:104])
        else $error("clock cycle access changed");
    tran_rate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        transfer_rate == csd_pkg::CSD_RESET[103:96])
        else $error("transfer rate changed");

    cmd_class_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        command_classes == csd_pkg::CSD_RESET[95:84])
        else $error("command classes changed");
    rd_blk_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        read_block_length == csd_pkg::CSD_RESET[83:80])
        else $error("read block length changed");
    rd_partial_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        partial_read_allowed == csd_pkg::CSD_RESET[79])
        else $error("partial read flag changed");
    wr_misalign_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        write_misaligned_allowed == csd_pkg::CSD_RESET[78])
        else $error("write misaligned flag changed");
    rd_misalign_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        read_misaligned_allowed == csd_pkg::CSD_RESET[77])
        else $error("read misaligned flag changed");
    drv_stage_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        driver_stage_present == csd_pkg::CSD_RESET[76])
        else $error("driver stage flag changed");
    mid_rsvd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rsvd_mid == csd_pkg::CSD_RESET[75:70])
        else $error("middle reserved bits changed");

    dev_size_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        device_size == csd_pkg::CSD_RESET[69:48])
        else $error("device size changed");
    bit47_rsvd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rsvd_47 == csd_pkg::CSD_RESET[47])
        else $error("bit 47 changed");
    erase_en_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        single_block_erase_enable == csd_pkg::CSD_RESET[46])
        else $error("erase enable changed");
    sector_size_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        erase_sector_size == csd_pkg::CSD_RESET[45:39])
        else $error("sector size changed");
    grp_size_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        protect_group_size == csd_pkg::CSD_RESET[38:32])
        else $error("protect group size changed");
    grp_enable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        protect_group_enable == csd_pkg::CSD_RESET[31])
        else $error("protect group enable changed");
    rsvd30_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rsvd_30 == csd_pkg::CSD_RESET[30:29])
        else $error("bits 30 and 29 changed");

    read_to_write_factor_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        read_to_write_factor == csd_pkg::CSD_RESET[28:26])
        else $error("speed factor changed");
    wr_blk_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        write_block_length == csd_pkg::CSD_RESET[25:22])
        else $error("write block length changed");
    wr_partial_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        partial_write_allowed == csd_pkg::CSD_RESET[21])
        else $error("partial write flag changed");
    low_rsvd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rsvd_low == csd_pkg::CSD_RESET[20:16])
        else $error("low reserved bits changed");
    file_fmt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        code_a == csd_pkg::CSD_RESET[11:10])
        else $error("code_a changed");
    rsvd9_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rsvd_9 == csd_pkg::CSD_RESET[9:8])
        else $error("bits 9 and 8 changed");
    unused_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        unused_one == 1'b1)
        else $error("unused bit not one");

    ////////////////////////////////////////////////////////////////
    fixed_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (card_specific_data_r & ~csd_pkg::CSD_WR_MASK)
            == (csd_pkg::CSD_RESET & ~csd_pkg::CSD_WR_MASK))
        else $error("read-only field changed");
    bit_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        csd_rvalid |-> csd_rdata[0] == 1'b1)
        else $error("bit 0 not one");
    read_back_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        csd_read |=> csd_rdata == $past(card_specific_data_r))
        else $error("read data mismatch");
    otp_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(card_specific_data_r[csd_pkg::PWP_BIT]) |-> 1'b0)
        else $error("one-time bit cleared");
    prog_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(program_card_data_command) |-> $stable(card_specific_data_r))
        else $error("register changed without program");
    prog_err_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        program_error |-> $stable(card_specific_data_r))
        else $error("register changed on program error");
    tmp_wp_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        program_done |-> card_specific_data_r[csd_pkg::TWP_BIT]
            == $past(program_data[csd_pkg::TWP_BIT]))
        else $error("temporary protect not written");
    rca_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rca_write |=> relative_card_address == $past(rca_wdata))
        else $error("address not written");
    struct_ver_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        card_specific_data_r[127:120] == 8'h40)
        else $error("structure version wrong");

    // behaviour of the program, read and address paths
    rd_fixed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        csd_rvalid |-> (csd_rdata & ~csd_pkg::CSD_WR_MASK) == (csd_pkg::CSD_RESET & ~csd_pkg::CSD_WR_MASK))
        else $error("read data fixed bits wrong");
    rvalid_next_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        csd_read |=> csd_rvalid)
        else $error("read not answered");
    rdata_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !csd_read |=> $stable(csd_rdata))
        else $error("read data moved without read");
    prog_resp_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        program_card_data_command |=> (program_done || program_error))
        else $error("program not answered");
    done_err_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(program_done && program_error))
        else $error("done and error together");
    ffg_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        card_specific_data_r[csd_pkg::FFG_BIT] |=> card_specific_data_r[csd_pkg::FFG_BIT])
        else $error("code_a group bit cleared");
    copy_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        card_specific_data_r[csd_pkg::COPY_BIT] |=> card_specific_data_r[csd_pkg::COPY_BIT])
        else $error("copy bit cleared");
    pwp_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        card_specific_data_r[csd_pkg::PWP_BIT] |=> card_specific_data_r[csd_pkg::PWP_BIT])
        else $error("permanent protect bit cleared");
    otp_track_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        otp_done_r == card_specific_data_r[15:13])
        else $error("one-time lock out of step");
    checksum_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        program_done |-> checksum == $past(program_data[7:1]))
        else $error("checksum not written");
    rca_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rca_write |=> $stable(relative_card_address))
        else $error("address moved without write");

endmodule // csd_regs

// ### dv/host_bringup.sv
`timescale 1ns/10ps
module host_bringup (
    input wire logic core_clk,
    input wire logic rst_n,
    output logic cmd_line,
    output logic ready
);
    logic [6:0] cnt_r;
    // pins low while unpowered, then count clocks with command high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) cnt_r <= 7'h00;
        else if (cnt_r != 7'h4A) cnt_r <= cnt_r + 7'h01;
    end
    assign cmd_line = rst_n;
    assign ready = (cnt_r == 7'h4A);
endmodule // host_bringup

// ### dv/sd_card_specific_data_regs_tb.sv
`timescale 1ns/10ps
module sd_card_specific_data_regs_tb;
    logic core_clk = 1'b0, rst_n = 1'b0, csd_read = 1'b0, cmd = 1'b0;
    logic rca_write = 1'b0, wpend = 1'b0, csd_rvalid, program_done, program_error, ready;
    logic [127:0] program_data = 128'h0, csd_rdata, m, m0, d;
    logic [15:0] rca_wdata = 16'h0000, relative_card_address;
    logic [127:0] q_rd[$];
    logic q_pg[$];
    logic [15:0] q_ra[$];
    int num_errors = 0, checked = 0;
    always #50 core_clk = ~core_clk;
    csd_regs dut (.core_clk(core_clk), .rst_n(rst_n), .csd_read(csd_read),
        .program_card_data_command(cmd), .program_data(program_data),
        .rca_write(rca_write), .rca_wdata(rca_wdata), .csd_rdata(csd_rdata),
        .csd_rvalid(csd_rvalid), .program_done(program_done),
        .program_error(program_error), .relative_card_address(relative_card_address));
    host_bringup host (.core_clk(core_clk), .rst_n(rst_n), .cmd_line(), .ready(ready));
    ////////////////////////////////////////
    task automatic bad(string s);
        num_errors++;
        $display("[FAIL] %0t %s", $time, s);
    endtask
    task automatic cmp_rd(logic [127:0] g, logic [127:0] e);
        checked++;
        if (g !== e) bad("read data");
    endtask
    task automatic cmp_pg(logic g, logic e);
        checked++;
        if (g !== e) bad("program outcome");
    endtask
    task automatic cmp_ra(logic [15:0] g, logic [15:0] e);
        checked++;
        if (g !== e) bad("card address");
    endtask
    function automatic logic err(logic [127:0] x);
        return |((x ^ m) & ~csd_pkg::CSD_WR_MASK) || |((x[15:13] ^ m[15:13]) & m[15:13]);
    endfunction
    task automatic drive(logic r, logic p, logic w, logic [127:0] dd, logic [15:0] a);
        @(posedge core_clk);
        csd_read <= r;
        cmd <= p;
        rca_write <= w;
        program_data <= dd;
        rca_wdata <= a;
        if (r) q_rd.push_back(m);
        if (w) q_ra.push_back(a);
        if (p) q_pg.push_back(err(dd));
        if (p && !err(dd)) m = dd;
    endtask
    task automatic wrap_up();
        if (q_rd.size() + q_pg.size() + q_ra.size() != 0) num_errors++;
        $display("errors %0d checked %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) wpend <= rca_write;
    always @(negedge core_clk) begin
        if (csd_rvalid === 1'b1) cmp_rd(csd_rdata, q_rd.pop_front());
        if (program_done === 1'b1 || program_error === 1'b1)
        begin
            d[0] = q_pg.pop_front();
            cmp_pg(program_error, d[0]);
            cmp_pg(program_done, !d[0]);
        end
        if (wpend) cmp_ra(relative_card_address, q_ra.pop_front());
    end
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
    initial begin
        m0 = {2'b01, 6'h00, 8'h0E, 8'h00, 8'h32, 12'h5B5, 4'h9, 4'h0, 6'h00, 22'h1CDF, 1'b0,
            1'b1, 7'h3F, 7'h00, 1'b0, 2'h0, 3'h2, 4'h9, 1'b0, 5'h00, 4'h0, 2'h0, 2'h0, 7'h6B, 1'b1};
        void'($urandom(71523));
        for (int i = 0; i < 2; i++) begin
            rst_n <= 1'b0;
            m = m0;
            repeat (10) @(posedge core_clk);
            rst_n <= 1'b1;
            wait (ready === 1'b1);
            cmp_ra(relative_card_address, 16'h0000);
            drive(1, 0, 0, m, 16'h0000);
            for (int k = 0; k < 24; k++) begin
                d = m ^ ({$urandom, $urandom, $urandom, $urandom}
                    & ((k % 4 == 0) ? ~128'h0 : csd_pkg::CSD_WR_MASK));
                drive(k[0], 1, k[1], d, 16'($urandom));
            end
            drive(1, 0, 0, m, 16'h0000);
            drive(0, 0, 0, m, 16'h0000);
            repeat (2) @(posedge core_clk);
        end
        wrap_up();
    end
endmodule // sd_card_specific_data_regs_tb
